/* File: logic/nvm_jtag_programmer.sv */
// Boundary-scan programming host for on-chip flash, EEPROM and fuses
`timescale 1ns/1ps
`default_nettype none

// Function
// - Page data shifted LSB of first word first, MSB of last word last.
// - First eight dumped bits are discarded; page data follows LSB first.
// - Entry: reset register gets one, then enable register gets signature.
// - Exit: no-operation, clear enable register, then reset register zero.
// - Chip erase is ended by polling completion or waiting erase time.
// - Chip erase must come before any flash or EEPROM programming; only page fill is refused before it here.
// - Word flash write: address, data, latch per word, then page write.
// - Page fill needs zero in-page word index and return to commands.
// - Word flash read: enable read, load address, issue read command.
// - Page dump starts at zero word index, then returns to commands.
// - EEPROM write: address and data per byte, then page write.
// - Page fill chain is never used for EEPROM.
// - Page dump chain is never used for EEPROM.
// - Fuse high byte then low byte; zero programs, one unprograms.
// - A poll repeats until the completion bit reads one; here it stops with an error after MAX_POLLS tries.
// - No-operation is two 15-bit command words in order.
module nvm_jtag_programmer #(
  parameter int PAGE_BYTES = 128,
  parameter int MAX_POLLS = 4096,
  parameter int WRITE_WAIT_NS = 10000,
  parameter int ERASE_WAIT_NS = 20000
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Operation request
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [3:0] cmd_op,
  input wire logic [14:0] cmd_word,
  input wire logic cmd_erase,
  // Operation result
  output logic rsp_valid,
  output logic rsp_err,
  output logic [14:0] rsp_data,
  // Page data in
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [7:0] in_data,
  // Page data out
  output logic out_valid,
  input wire logic out_ready,
  output logic [7:0] out_data,
  // Mode status
  output logic prog_mode,
  output logic erased,
  // Tap pins
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo
);

  // ****************************************************************
  // Derived counts
  // ****************************************************************
  localparam int PAGE_BITS = PAGE_BYTES * nvm_prog_pkg::BYTE_BITS;
  localparam int DUMP_BITS = PAGE_BITS + nvm_prog_pkg::DUMP_PAD_BITS;
  localparam int WRITE_WAIT_CYC =
    (WRITE_WAIT_NS + nvm_prog_pkg::CLK_NS - 1) / nvm_prog_pkg::CLK_NS;
  localparam int ERASE_WAIT_CYC =
    (ERASE_WAIT_NS + nvm_prog_pkg::CLK_NS - 1) / nvm_prog_pkg::CLK_NS;
  localparam logic [31:0] LAST_BYTE = 32'(PAGE_BYTES - 1);

  // ****************************************************************
  // Scan plan per operation step
  // ****************************************************************
  function automatic nvm_prog_pkg::scan_s plan(input nvm_prog_pkg::op_e op,
                                               input logic [2:0] step,
                                               input logic [14:0] word);
    nvm_prog_pkg::scan_s s;
    logic [15:0] ir_code;
    s.last = 1'b0;
    s.ir = 1'b0;
    s.len = nvm_prog_pkg::LEN_W'(nvm_prog_pkg::CMD_LEN);
    s.data = {1'b0, word};
    ir_code = nvm_prog_pkg::program_command_instr;
    unique case (op)
      nvm_prog_pkg::OP_ENTER: begin
        s.last = (step == 3'h3);
        ir_code = step[1] ? nvm_prog_pkg::program_mode_entry_instr
                          : nvm_prog_pkg::device_reset_instr;
        s.len = step[1] ? nvm_prog_pkg::LEN_W'(nvm_prog_pkg::ENABLE_LEN)
                        : nvm_prog_pkg::LEN_W'(nvm_prog_pkg::RESET_LEN);
        s.data = step[1] ? nvm_prog_pkg::ENABLE_SIGNATURE
                         : nvm_prog_pkg::RESET_ON;
      end
      nvm_prog_pkg::OP_LEAVE: begin
        s.last = (step == 3'h6);
        unique case (step)
          3'h1: s.data = nvm_prog_pkg::NOP_WORD_A;
          3'h2: s.data = nvm_prog_pkg::NOP_WORD_B;
          3'h3: ir_code = nvm_prog_pkg::program_mode_entry_instr;
          3'h4: begin
            s.len = nvm_prog_pkg::LEN_W'(nvm_prog_pkg::ENABLE_LEN);
            s.data = nvm_prog_pkg::ENABLE_CLEAR;
          end
          3'h5: ir_code = nvm_prog_pkg::device_reset_instr;
          3'h6: begin
            s.len = nvm_prog_pkg::LEN_W'(nvm_prog_pkg::RESET_LEN);
            s.data = nvm_prog_pkg::RESET_OFF;
          end
          default: ir_code = nvm_prog_pkg::program_command_instr;
        endcase
      end
      nvm_prog_pkg::OP_PAGE_LOAD: begin
        s.last = (step == 3'h2);
        ir_code = (step == 3'h0) ? nvm_prog_pkg::page_fill_chain_instr
                                 : nvm_prog_pkg::program_command_instr;
        s.len = nvm_prog_pkg::LEN_W'(PAGE_BITS);
      end
      nvm_prog_pkg::OP_PAGE_READ: begin
        s.last = (step == 3'h2);
        ir_code = (step == 3'h0) ? nvm_prog_pkg::page_dump_chain_instr
                                 : nvm_prog_pkg::program_command_instr;
        s.len = nvm_prog_pkg::LEN_W'(DUMP_BITS);
      end
      default: s.last = (step == 3'h1);
    endcase
    if (!step[0] && op != nvm_prog_pkg::OP_LEAVE || op ==
        nvm_prog_pkg::OP_LEAVE && (step == 3'h0 || step == 3'h3 ||
        step == 3'h5)) begin
      s.ir = 1'b1;
      s.len = nvm_prog_pkg::LEN_W'(nvm_prog_pkg::IR_LEN);
      s.data = ir_code;
    end
    return s;
  endfunction

  // ****************************************************************
  // Engine
  // ****************************************************************
  typedef enum logic [1:0] {M_IDLE, M_SCAN, M_WAIT, M_RESP} mst_e;

  mst_e st_q;
  nvm_prog_pkg::op_e op_q;
  nvm_prog_pkg::scan_s cur;
  logic [2:0] step_q;
  logic [14:0] word_q;
  logic mark_erase_q;
  logic go_q;
  logic [15:0] sh_q, cap_q;
  logic [7:0] fill_q, dump_q;
  logic [2:0] bit_q;
  logic [31:0] byte_q, timer_q, polls_q;
  logic eng_busy, eng_bit, eng_tdo, eng_done, hold, tdi_src;
  logic fill_dr, dump_dr;

  assign cur = plan(op_q, step_q, word_q);
  assign fill_dr = (op_q == nvm_prog_pkg::OP_PAGE_LOAD) && step_q == 3'h1;
  assign dump_dr = (op_q == nvm_prog_pkg::OP_PAGE_READ) && step_q == 3'h1;
  assign tdi_src = fill_dr ? fill_q[bit_q] : sh_q[0];
  // Stall the tap clock rather than lose a byte either way
  assign hold = (fill_dr && in_ready) || (dump_dr && out_valid);

  tap_scan_engine #(.HALF(nvm_prog_pkg::TCK_HALF)) u_engine (
    .sys_clk(sys_clk),
    .reset(reset),
    .start(go_q),
    .is_ir(cur.ir),
    .len(cur.len),
    .hold(hold),
    .tdi_bit(tdi_src),
    .busy(eng_busy),
    .bit_done(eng_bit),
    .tdo_bit(eng_tdo),
    .done(eng_done),
    .tck(tck),
    .tms(tms),
    .tdi(tdi),
    .tdo(tdo)
  );

  // ****************************************************************
  // Operation sequencer
  // ****************************************************************
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      st_q <= M_IDLE;
      op_q <= nvm_prog_pkg::OP_CMD;
      step_q <= '0;
      word_q <= '0;
      mark_erase_q <= 1'b0;
      go_q <= 1'b0;
      timer_q <= '0;
      polls_q <= '0;
      cmd_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_err <= 1'b0;
      rsp_data <= '0;
      prog_mode <= 1'b0;
      erased <= 1'b0;
    end else begin
      go_q <= 1'b0;
      rsp_valid <= 1'b0;
      unique case (st_q)
        M_IDLE: begin
          cmd_ready <= !eng_busy;
          if (cmd_valid && cmd_ready) begin
            cmd_ready <= 1'b0;
            op_q <= nvm_prog_pkg::op_e'(cmd_op);
            word_q <= cmd_word;
            mark_erase_q <= cmd_erase;
            step_q <= '0;
            polls_q <= '0;
            rsp_err <= 1'b0;
            if (!prog_mode && cmd_op != 4'(nvm_prog_pkg::OP_ENTER) ||
                cmd_op > 4'(nvm_prog_pkg::OP_PAGE_READ)) begin
              rsp_err <= 1'b1;
              st_q <= M_RESP;
            end else if (cmd_op == 4'(nvm_prog_pkg::OP_PAGE_LOAD) &&
                         !erased) begin
              rsp_err <= 1'b1;
              st_q <= M_RESP;
            end else if (cmd_op == 4'(nvm_prog_pkg::OP_WAIT_WRITE)) begin
              timer_q <= 32'(WRITE_WAIT_CYC);
              st_q <= M_WAIT;
            end else if (cmd_op == 4'(nvm_prog_pkg::OP_WAIT_ERASE)) begin
              timer_q <= 32'(ERASE_WAIT_CYC);
              st_q <= M_WAIT;
            end else begin
              go_q <= 1'b1;
              st_q <= M_SCAN;
            end
          end
        end
        M_SCAN: begin
          if (eng_done) begin
            if (!cur.ir && !cur.last)
              rsp_data <= cap_q[15:1];
            if (op_q == nvm_prog_pkg::OP_POLL && !cur.ir &&
                !cap_q[nvm_prog_pkg::POLL_BIT + 1]) begin
              polls_q <= polls_q + 1'b1;
              if (polls_q == 32'(MAX_POLLS - 1)) begin
                rsp_err <= 1'b1;
                st_q <= M_RESP;
              end else begin
                go_q <= 1'b1;
              end
            end else if (cur.last) begin
              if (!cur.ir)
                rsp_data <= cap_q[15:1];
              st_q <= M_RESP;
              if (op_q == nvm_prog_pkg::OP_ENTER)
                prog_mode <= 1'b1;
              if (op_q == nvm_prog_pkg::OP_LEAVE) begin
                prog_mode <= 1'b0;
                erased <= 1'b0;
              end
              if (op_q == nvm_prog_pkg::OP_POLL && mark_erase_q)
                erased <= 1'b1;
            end else begin
              step_q <= step_q + 1'b1;
              go_q <= 1'b1;
            end
          end
        end
        M_WAIT: begin
          timer_q <= timer_q - 1'b1;
          if (timer_q <= 32'h0000_0001) begin
            st_q <= M_RESP;
            if (op_q == nvm_prog_pkg::OP_WAIT_ERASE)
              erased <= 1'b1;
          end
        end
        default: begin
          rsp_valid <= 1'b1;
          st_q <= M_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // Short scan shifter
  // ****************************************************************
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      sh_q <= '0;
      cap_q <= '0;
    end else if (go_q) begin
      sh_q <= cur.data;
      cap_q <= '0;
    end else if (eng_bit) begin
      sh_q <= {1'b0, sh_q[15:1]};
      cap_q <= {eng_tdo, cap_q[15:1]};
    end
  end

  // ****************************************************************
  // Page streams
  // ****************************************************************
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      fill_q <= '0;
      dump_q <= '0;
      bit_q <= '0;
      byte_q <= '0;
      in_ready <= 1'b0;
      out_valid <= 1'b0;
      out_data <= '0;
    end else begin
      if (out_valid && out_ready)
        out_valid <= 1'b0;
      if (in_valid && in_ready) begin
        fill_q <= in_data;
        in_ready <= 1'b0;
      end
      if (go_q) begin
        bit_q <= '0;
        byte_q <= '0;
        in_ready <= fill_dr;
      end else if (eng_bit && (fill_dr || dump_dr)) begin
        bit_q <= bit_q + 1'b1;
        dump_q <= {eng_tdo, dump_q[7:1]};
        if (bit_q == 3'h7) begin
          byte_q <= byte_q + 1'b1;
          if (fill_dr && byte_q != LAST_BYTE)
            in_ready <= 1'b1;
          if (dump_dr && byte_q != '0) begin
            out_data <= {eng_tdo, dump_q[7:1]};
            out_valid <= 1'b1;
          end
        end
      end
    end
  end

endmodule

`default_nettype wire

/* File: pkg/nvm_prog_pkg.sv */
// Constants and types shared by the programming host and its scan engine
package nvm_prog_pkg;

  // ****************************************************************
  // Scan geometry
  // ****************************************************************
  localparam int LEN_W = 16;
  localparam int IR_LEN = 4;
  localparam int CMD_LEN = 15;
  localparam int ENABLE_LEN = 16;
  localparam int RESET_LEN = 1;
  localparam int BYTE_BITS = 8;
  localparam int DUMP_PAD_BITS = 8;
  localparam int POLL_BIT = 9;

  // ****************************************************************
  // Instruction codes (plain defaults, not taken from any part)
  // ****************************************************************
  localparam logic [15:0] device_reset_instr = 16'h000c;
  localparam logic [15:0] program_mode_entry_instr = 16'h0004;
  localparam logic [15:0] program_command_instr = 16'h0005;
  localparam logic [15:0] page_fill_chain_instr = 16'h0006;
  localparam logic [15:0] page_dump_chain_instr = 16'h0007;

  // ****************************************************************
  // Data register words
  // ****************************************************************
  localparam logic [15:0] ENABLE_SIGNATURE = 16'ha370;
  localparam logic [15:0] ENABLE_CLEAR = 16'h0000;
  localparam logic [15:0] RESET_ON = 16'h0001;
  localparam logic [15:0] RESET_OFF = 16'h0000;
  localparam logic [15:0] NOP_WORD_A = 16'h2300;
  localparam logic [15:0] NOP_WORD_B = 16'h3300;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_NS = 8;
  localparam int TCK_HALF = 4;

  // Tap walk: five ones reach test-logic-reset, a zero parks in idle
  localparam logic [5:0] TLR_PAT = 6'h1f;
  localparam logic [5:0] TLR_N = 6'h06;
  localparam logic [5:0] DR_PAT = 6'h01;
  localparam logic [5:0] DR_N = 6'h03;
  localparam logic [5:0] IR_PAT = 6'h03;
  localparam logic [5:0] IR_N = 6'h04;

  typedef enum logic [3:0] {
    OP_ENTER,
    OP_LEAVE,
    OP_CMD,
    OP_POLL,
    OP_WAIT_WRITE,
    OP_WAIT_ERASE,
    OP_PAGE_LOAD,
    OP_PAGE_READ
  } op_e;

  typedef struct packed {
    logic last;
    logic ir;
    logic [LEN_W-1:0] len;
    logic [15:0] data;
  } scan_s;

endpackage

/* File: logic/tap_scan_engine.sv */
// Bit-level scan engine: drives tck, tms and tdi and samples tdo
`timescale 1ns/1ps
`default_nettype none

module tap_scan_engine #(
  parameter int HALF = nvm_prog_pkg::TCK_HALF
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Scan request
  input wire logic start,
  input wire logic is_ir,
  input wire logic [nvm_prog_pkg::LEN_W-1:0] len,
  input wire logic hold,
  input wire logic tdi_bit,
  // Scan progress
  output logic busy,
  output logic bit_done,
  output logic tdo_bit,
  output logic done,
  // Tap pins
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo
);

  // ****************************************************************
  // Tdo synchroniser
  // ****************************************************************
  logic tdo_s1_q, tdo_s2_q;

  always_ff @(posedge sys_clk) begin
    tdo_s1_q <= tdo;
    tdo_s2_q <= tdo_s1_q;
  end

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  typedef enum logic [1:0] {S_IDLE, S_PRE, S_SHIFT, S_POST} st_e;
  localparam int PH_W = $clog2(2 * HALF);
  localparam logic [PH_W-1:0] PH_RISE = PH_W'(HALF);
  localparam logic [PH_W-1:0] PH_LAST = PH_W'(2 * HALF - 1);
  localparam logic [PH_W-1:0] PH_TAKE = PH_W'(2 * HALF - 2);

  st_e st_q;
  logic [PH_W-1:0] ph_q;
  logic [nvm_prog_pkg::LEN_W-1:0] cnt_q, len_q;
  logic [5:0] pat_q, pat_n_q;
  logic tlr_q;

  assign busy = (st_q != S_IDLE) || start;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      st_q <= S_PRE;
      ph_q <= '0;
      cnt_q <= '0;
      len_q <= '0;
      pat_q <= nvm_prog_pkg::TLR_PAT;
      pat_n_q <= nvm_prog_pkg::TLR_N;
      tlr_q <= 1'b1;
      bit_done <= 1'b0;
      tdo_bit <= 1'b0;
      done <= 1'b0;
      tck <= 1'b0;
      tms <= 1'b0;
      tdi <= 1'b0;
    end else begin
      bit_done <= 1'b0;
      done <= 1'b0;
      if (st_q == S_IDLE) begin
        tck <= 1'b0;
        tms <= 1'b0;
        tdi <= 1'b0;
        ph_q <= '0;
        cnt_q <= '0;
        if (start) begin
          st_q <= S_PRE;
          len_q <= len;
          pat_q <= is_ir ? nvm_prog_pkg::IR_PAT : nvm_prog_pkg::DR_PAT;
          pat_n_q <= is_ir ? nvm_prog_pkg::IR_N : nvm_prog_pkg::DR_N;
        end
      end else if (ph_q == '0) begin
        // Tck falls here; the far end moves tdo on this edge
        tck <= 1'b0;
        unique case (st_q)
          S_PRE: tms <= pat_q[cnt_q[2:0]];
          S_SHIFT: tms <= (cnt_q == len_q - 1'b1);
          default: tms <= (cnt_q == '0);
        endcase
        tdi <= (st_q == S_SHIFT) ? tdi_bit : 1'b0;
        // Stall in any state, so no tck edge runs while a byte waits
        if (!hold)
          ph_q <= ph_q + 1'b1;
      end else if (ph_q == PH_RISE) begin
        tck <= 1'b1;
        ph_q <= ph_q + 1'b1;
      end else if (ph_q == PH_TAKE && st_q == S_SHIFT) begin
        // A phase early so the user moves its next bit before tck falls
        bit_done <= 1'b1;
        tdo_bit <= tdo_s2_q;
        ph_q <= ph_q + 1'b1;
      end else if (ph_q == PH_LAST) begin
        // Late in the high phase so the synchroniser has settled
        ph_q <= '0;
        unique case (st_q)
          S_PRE: begin
            if (cnt_q == {10'h000, pat_n_q} - 1'b1) begin
              cnt_q <= '0;
              st_q <= tlr_q ? S_IDLE : S_SHIFT;
              tlr_q <= 1'b0;
            end else begin
              cnt_q <= cnt_q + 1'b1;
            end
          end
          S_SHIFT: begin
            if (cnt_q == len_q - 1'b1) begin
              cnt_q <= '0;
              st_q <= S_POST;
            end else begin
              cnt_q <= cnt_q + 1'b1;
            end
          end
          default: begin
            if (cnt_q != '0) begin
              st_q <= S_IDLE;
              done <= 1'b1;
            end
            cnt_q <= cnt_q + 1'b1;
          end
        endcase
      end else begin
        ph_q <= ph_q + 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

/* File: verif/nvm_prog_props.sv */
// Checker for the programming host's port behaviour
`timescale 1ns/1ps
`default_nettype none

module nvm_prog_props #(
  parameter int PAGE_BYTES = 128
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Requests and results
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire logic [3:0] cmd_op,
  input wire logic [14:0] cmd_word,
  input wire logic cmd_erase,
  input wire logic rsp_valid,
  input wire logic rsp_err,
  input wire logic [14:0] rsp_data,
  // Byte streams
  input wire logic in_valid,
  input wire logic in_ready,
  input wire logic [7:0] in_data,
  input wire logic out_valid,
  input wire logic out_ready,
  input wire logic [7:0] out_data,
  // Status and tap
  input wire logic prog_mode,
  input wire logic erased,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic tdo
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);

  // Refusal answers without touching the tap
  sequence s_refused;
    ##2 rsp_valid && rsp_err;
  endsequence

  sequence s_tck_high;
    tck [*4] ##1 !tck;
  endsequence

  a_entry_first: assert property (
    cmd_valid && cmd_ready && !prog_mode && cmd_op != 4'h0 |-> s_refused)
    else $error("request taken outside programming mode");
  a_erase_first: assert property (
    cmd_valid && cmd_ready && prog_mode && !erased && cmd_op == 4'h6
    |-> s_refused) else $error("page fill taken before erase");
  a_tck_width: assert property (
    $rose(tck) |-> s_tck_high) else $error("tck high phase wrong");
  a_tap_steady: assert property (
    tck && $past(tck) |-> $stable(tms) && $stable(tdi))
    else $error("tms or tdi moved while tck high");
  a_fill_stall: assert property (
    (in_ready && !in_valid) [*5] |-> !tck)
    else $error("tck runs while fill byte missing");
  a_dump_hold: assert property (
    out_valid && !out_ready |=> out_valid && $stable(out_data))
    else $error("dump byte dropped before taken");
  a_dump_stall: assert property (
    (out_valid && !out_ready) [*5] |-> !tck)
    else $error("tck runs while dump byte waits");
  a_rsp_pulse: assert property (
    rsp_valid |=> !rsp_valid) else $error("response longer than a cycle");
endmodule

bind nvm_jtag_programmer nvm_prog_props #(.PAGE_BYTES(PAGE_BYTES)) u_props (
  .sys_clk, .reset, .cmd_valid, .cmd_ready, .cmd_op, .cmd_word, .cmd_erase,
  .rsp_valid, .rsp_err, .rsp_data, .in_valid, .in_ready, .in_data,
  .out_valid, .out_ready, .out_data, .prog_mode, .erased,
  .tck, .tms, .tdi, .tdo
);

`default_nettype wire

/* File: verif/nvm_dev_model.sv */
// Behavioural model of the device's scan programming access
`timescale 1ns/1ps
`default_nettype none

module nvm_dev_model (
  // Tap pins
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  // Completion never reported while high
  input wire logic slow
);
  logic [3:0] st = 4'h0;
  logic [3:0] ir = 4'hf;
  logic [3:0] irs, i_cmd, i_fill, i_dump, i_rst, i_ena;
  logic [31:0] sr, v;
  logic [15:0] n, idx, reset_q, enable_q, dump_n;
  logic [15:0] polls = 16'h0;
  logic [14:0] w_a, w_b;
  logic [7:0] fb;
  logic [7:0] addr = 8'h00;
  logic [7:0] lock = 8'hff;
  logic [7:0] mem [256];

  assign i_cmd = nvm_prog_pkg::program_command_instr[3:0];
  assign i_fill = nvm_prog_pkg::page_fill_chain_instr[3:0];
  assign i_dump = nvm_prog_pkg::page_dump_chain_instr[3:0];
  assign i_rst = nvm_prog_pkg::device_reset_instr[3:0];
  assign i_ena = nvm_prog_pkg::program_mode_entry_instr[3:0];

  initial begin
    tdo = 1'b0;
    foreach (mem[j]) mem[j] = 8'(j);
  end

  always @(posedge tck) begin
    v = sr >> (16'd32 - n);
    case (st)
      4'h3: begin
        n <= 16'h0;
        sr <= {22'h0, !slow && polls > 1, 1'b0, mem[addr]};
        polls <= polls + 16'h1;
      end
      4'h4: begin
        sr <= {tdi, sr[31:1]};
        fb <= {tdi, fb[7:1]};
        n <= n + 16'h1;
        if (ir == i_fill && n[2:0] == 3'h7) begin
          mem[addr + n[10:3]] <= {tdi, fb[7:1]};
        end
      end
      4'h6: begin
        if (ir == i_rst) reset_q <= v[15:0];
        if (ir == i_ena) enable_q <= v[15:0];
        if (ir == i_dump) dump_n <= n;
        if (ir == i_cmd) begin
          w_a <= w_b;
          w_b <= v[14:0];
          if (v[14:8] == 7'h03) addr <= v[7:0];
          if (v[14:8] == 7'h13) lock <= lock & v[7:0];
          if (v[14:0] != w_b) polls <= 16'h0;
        end
      end
      4'h8: irs <= 4'h1;
      4'h9: irs <= {tdi, irs[3:1]};
      4'hb: ir <= irs;
      4'h0: ir <= 4'hf;
      default: ;
    endcase
    case (st)
      4'h0: st <= tms ? 4'h0 : 4'h1;
      4'h2: st <= tms ? 4'h7 : 4'h3;
      4'h3, 4'h4: st <= tms ? 4'h5 : 4'h4;
      4'h5: st <= tms ? 4'h6 : 4'h5;
      4'h7: st <= tms ? 4'h0 : 4'h8;
      4'h8, 4'h9: st <= tms ? 4'ha : 4'h9;
      4'ha: st <= tms ? 4'hb : 4'ha;
      default: st <= tms ? 4'h2 : 4'h1;
    endcase
  end

  // Outside a shift the line toggles so a stale bit never looks valid
  always @(negedge tck) begin
    idx = n - 16'h8;
    if (st == 4'h4 && ir == i_dump) begin
      tdo <= n < 16'h8 ? n[0] : mem[addr + idx[10:3]][idx[2:0]];
    end else if (st == 4'h4 || st == 4'h9) begin
      tdo <= st == 4'h4 ? sr[0] : irs[0];
    end else begin
      tdo <= ~tdo;
    end
  end
endmodule

`default_nettype wire

/* File: verif/nvm_jtag_programmer_tb.sv */
// Self-checking bench for the scan programming host
`timescale 1ns/1ps
`default_nettype none

module nvm_jtag_programmer_tb;
  localparam int PB = 4;
  localparam logic [30:0] OK = 31'h0;
  localparam logic [30:0] ERR = 31'h1;
  logic sys_clk, reset, cmd_valid, cmd_ready, cmd_erase, rsp_valid, rsp_err;
  logic in_valid, in_ready, in_hs, out_valid, out_ready, prog_mode, erased;
  logic tck, tms, tdi, tdo, slow;
  logic [3:0] cmd_op;
  logic [14:0] cmd_word, rsp_data;
  logic [7:0] in_data, out_data;
  logic [7:0] pg [PB];
  logic [30:0] e;
  logic [30:0] rq [$];
  logic [7:0] iq [$];
  logic [7:0] oq [$];
  int n_fail, checks, n_rsp, ntck, t, k;

  nvm_jtag_programmer #(.PAGE_BYTES(PB), .MAX_POLLS(8),
    .WRITE_WAIT_NS(80), .ERASE_WAIT_NS(80)) u_dut (
    .sys_clk, .reset, .cmd_valid, .cmd_ready, .cmd_op, .cmd_word,
    .cmd_erase, .rsp_valid, .rsp_err, .rsp_data, .in_valid, .in_ready,
    .in_data, .out_valid, .out_ready, .out_data, .prog_mode, .erased,
    .tck, .tms, .tdi, .tdo
  );

  nvm_dev_model u_dev (.tck, .tms, .tdi, .tdo, .slow);

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tend();
    t++;
    $display("test %0d done", t);
  endtask

  // Request held until taken, then one response awaited
  task automatic op(input logic [3:0] o, input logic [14:0] w,
                    input logic [30:0] x);
    int i, r;
    i = 0;
    r = n_rsp;
    rq.push_back(x);
    cmd_op = o;
    cmd_word = w;
    cmd_valid = 1'b1;
    do begin
      @(posedge sys_clk);
      i++;
    end while (!cmd_ready && i < 200);
    @(negedge sys_clk);
    cmd_valid = 1'b0;
    while (n_rsp == r && i < 30000) begin
      @(negedge sys_clk);
      i++;
    end
    if (n_rsp == r) begin
      n_fail++;
      give_verdict();
    end
  endtask

  always @(posedge tck) ntck++;

  always @(posedge sys_clk) begin
    in_hs <= in_valid && in_ready;
    if (rsp_valid) begin
      e = rq.size() > 0 ? rq.pop_front() : 31'h7fffffff;
      cmp_word({1'b0, rsp_data & e[30:16]}, {1'b0, e[15:1]});
      cmp_word({15'h0, rsp_err}, {15'h0, e[0]});
      n_rsp++;
    end
    if (out_valid && out_ready) begin
      cmp_word({8'h0, out_data}, {8'h0, oq.pop_front()});
    end
  end

  // Far side stalls at random on both byte streams
  always @(negedge sys_clk) begin
    out_ready <= 1'($urandom_range(1));
    if (in_hs) begin
      in_valid <= 1'b0;
    end else if (!in_valid && iq.size() > 0 && $urandom_range(1) == 1) begin
      in_data <= iq.pop_front();
      in_valid <= 1'b1;
    end
  end

  initial begin
    {reset, slow, in_hs, in_valid, out_ready, cmd_valid} = 6'h20;
    {cmd_erase, cmd_op, cmd_word, in_data} = 28'h0;
    void'($urandom(32'h1bb8));
    repeat (16) @(posedge sys_clk);
    @(negedge sys_clk);
    reset = 1'b0;
    op(4'h2, 15'($urandom), ERR);
    k = ntck;
    op(4'h8, 15'h0, ERR);
    cmp_word(16'(ntck - k), 16'h0);
    op(4'h0, 15'h0, OK);
    cmp_word(u_dev.reset_q, nvm_prog_pkg::RESET_ON);
    cmp_word(u_dev.enable_q, nvm_prog_pkg::ENABLE_SIGNATURE);
    op(4'h6, 15'h0, ERR);
    tend();
    op(4'h2, 15'($urandom) | 15'h4000, OK);
    cmd_erase = 1'b1;
    op(4'h3, 15'h3180, {15'h0200, 15'h0200, 1'b0});
    cmd_erase = 1'b0;
    cmp_word({15'h0, erased}, 16'h1);
    slow = 1'b1;
    op(4'h3, 15'h3300, ERR);
    slow = 1'b0;
    tend();
    op(4'h2, 15'h0300, OK);
    foreach (pg[i]) begin
      pg[i] = 8'($urandom);
      iq.push_back(pg[i]);
      oq.push_back(pg[i]);
    end
    op(4'h6, 15'h0, OK);
    foreach (pg[i]) cmp_word({8'h0, u_dev.mem[i]}, {8'h0, pg[i]});
    cmp_word({12'h0, u_dev.ir}, nvm_prog_pkg::program_command_instr);
    op(4'h7, 15'h0, OK);
    cmp_word(u_dev.dump_n, 16'(PB * 8 + 8));
    cmp_word(16'(oq.size()), 16'h0);
    op(4'h2, 15'h0302, OK);
    op(4'h2, 15'h3200, {15'h00ff, 7'h0, pg[2], 1'b0});
    op(4'h2, 15'h13f5, OK);
    op(4'h2, 15'h13fe, OK);
    cmp_word({8'h0, u_dev.lock}, 16'h00f4);
    tend();
    op(4'h1, 15'h0, OK);
    cmp_word({1'b0, u_dev.w_a}, nvm_prog_pkg::NOP_WORD_A);
    cmp_word({1'b0, u_dev.w_b}, nvm_prog_pkg::NOP_WORD_B);
    cmp_word(u_dev.enable_q, nvm_prog_pkg::ENABLE_CLEAR);
    cmp_word(u_dev.reset_q, nvm_prog_pkg::RESET_OFF);
    cmp_word({15'h0, prog_mode}, 16'h0);
    tend();
    reset = 1'b1;
    repeat (2) @(negedge sys_clk);
    reset = 1'b0;
    cmp_word({14'h0, prog_mode, erased}, 16'h0);
    op(4'h0, 15'h0, OK);
    op(4'h5, 15'h0, OK);
    cmp_word({15'h0, erased}, 16'h1);
    tend();
    give_verdict();
  end
endmodule

`default_nettype wire
